/* fmitd_pkg.sv */
// fmitd_pkg: constants, register map and carrier types of the fp/memory
// instruction decode block.
// assumes one core clock; the pipeline and the level-2 side share it.
package fmitd_pkg;

  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] OFF_FRS  = 8'h00;
  localparam logic [7:0] OFF_FST  = 8'h04;
  localparam logic [7:0] OFF_ASI  = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;

  // field positions
  localparam int FRS_LO       = 0;
  localparam int FRS_HI       = 1;
  localparam int EXC_W        = 5;
  localparam int FST_CEXC_LSB = 0;
  localparam int FST_AEXC_LSB = 5;
  localparam int FST_QNE      = 13;
  localparam int FST_TEM_LSB  = 23;
  localparam int ASI_PRIM_LSB = 0;
  localparam int ASI_KERN_LSB = 8;
  localparam int ASI_KLE_LSB  = 16;

  // address space id reset values (arbitrary)
  localparam logic [7:0] ASI_PRIM_RST = 8'h10;
  localparam logic [7:0] ASI_KERN_RST = 8'h20;
  localparam logic [7:0] ASI_KLE_RST  = 8'h28;

  // access sizes as log2 of bytes
  localparam logic [2:0] SZ_DW    = 3'h3;
  localparam logic [2:0] SZ_TWIN  = 3'h4;
  localparam logic [2:0] SZ_BLOCK = 3'h6;

  // prefetch function codes
  localparam logic [4:0] PF_PAGE   = 5'h04;
  localparam logic [4:0] PF_ILL_LO = 5'h05;
  localparam logic [4:0] PF_ILL_HI = 5'h0f;
  localparam logic [4:0] PF_INVAL  = 5'h18;
  localparam logic [4:0] PF_NOP_LO = 5'h19;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    CLS_NOP, CLS_FPOP, CLS_FMOVCC, CLS_GFX, CLS_FLD, CLS_FST, CLS_BLD,
    CLS_BST, CLS_LDD, CLS_STD, CLS_LDTW, CLS_PREF, CLS_FLUSH, CLS_RDPR,
    CLS_LDQF, CLS_STQF, CLS_FPQUAD, CLS_IMPL1, CLS_IMPL2, CLS_LD, CLS_ST
  } fmitd_cls_e;

  typedef enum logic [2:0] {
    TRAP_NONE, TRAP_ILLEGAL, TRAP_FP_IEEE, TRAP_LDDF_ALIGN, TRAP_STDF_ALIGN,
    TRAP_ALIGN
  } fmitd_trap_e;

  typedef enum logic [2:0] {
    MK_LOAD, MK_STORE, MK_PREF, MK_INVAL, MK_FLUSH
  } fmitd_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_REQ  = 3'b010,
    ST_FLW  = 3'b100
  } fmitd_state_e;

  typedef struct packed {
    fmitd_cls_e       cls;
    logic             dst_upper;
    logic             cond_ok;
    logic [EXC_W-1:0] fp_exc;
    logic [4:0]       fcn;
    logic             alt;
    logic [7:0]       asi;
    logic             pr_que;
    logic [2:0]       size;
    logic [47:0]      addr;
  } fmitd_issue_s;

  typedef struct packed {
    fmitd_kind_e kind;
    logic [47:0] addr;
    logic [2:0]  size;
    logic [7:0]  asi;
    logic        rmo;
    logic        atomic;
  } fmitd_mreq_s;

  typedef struct packed {
    fmitd_trap_e trap;
    logic [7:0]  asi;
  } fmitd_done_s;

endpackage

/* fmitd_top.sv */
// fmitd_top: decode, trap and dirty tracking for fp and memory
// instructions, with an axi4-lite slave for its state registers.
// assumes the pipeline, level-2 side and bus all run on clock.
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps

module fmitd_top (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire logic                   issue_valid,
  input  wire fmitd_pkg::fmitd_issue_s issue_insn,
  output logic                        issue_ready,
  input  wire logic [2:0]             trap_level,
  input  wire logic                   current_little_endian,
  input  wire logic                   hyperpriv,
  output logic                        done_valid,
  output fmitd_pkg::fmitd_done_s      done_info,
  output logic [7:0]                  fetch_asi,
  output logic                        fp_dirty_upper,
  output logic                        fp_dirty_lower,
  output logic                        mreq_valid,
  output fmitd_pkg::fmitd_mreq_s      mreq,
  input  wire logic                   mreq_ready,
  input  wire logic                   flush_ack,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready
);

  localparam int EW = fmitd_pkg::EXC_W;

  fmitd_pkg::fmitd_state_e state_r;
  fmitd_pkg::fmitd_state_e state_nxt;
  fmitd_pkg::fmitd_done_s  done_r;
  fmitd_pkg::fmitd_done_s  done_nxt;
  fmitd_pkg::fmitd_mreq_s  mreq_r;
  fmitd_pkg::fmitd_mreq_s  mreq_nxt;
  fmitd_pkg::fmitd_trap_e  trap_nxt;
  fmitd_pkg::fmitd_trap_e  last_trap_r;
  logic                    issue_ready_r;
  logic                    done_valid_r;
  logic                    mreq_valid_r;
  logic [7:0]              fetch_asi_r;
  logic                    hi_r;
  logic                    lo_r;
  logic                    pend_hi_r;
  logic                    pend_lo_r;
  logic [EW-1:0]           tem_r;
  logic [EW-1:0]           aexc_r;
  logic [EW-1:0]           cexc_r;
  logic [7:0]              asi_prim_r;
  logic [7:0]              asi_kern_r;
  logic [7:0]              asi_kle_r;
  logic                    awready_r;
  logic                    wready_r;
  logic                    bvalid_r;
  logic [1:0]              bresp_r;
  logic [7:0]              awaddr_r;
  logic [31:0]             wdata_r;
  logic [3:0]              wstrb_r;
  logic                    arready_r;
  logic                    rvalid_r;
  logic [1:0]              rresp_r;
  logic [31:0]             rdata_r;

  // ---------------- instruction decode ----------------
  fmitd_pkg::fmitd_issue_s iss;
  wire accept = issue_valid & issue_ready_r;
  assign iss = issue_insn;

  wire c_fpop   = iss.cls == fmitd_pkg::CLS_FPOP;
  wire c_fmov   = iss.cls == fmitd_pkg::CLS_FMOVCC;
  wire c_gfx    = iss.cls == fmitd_pkg::CLS_GFX;
  wire c_fld    = iss.cls == fmitd_pkg::CLS_FLD;
  wire c_fst    = iss.cls == fmitd_pkg::CLS_FST;
  wire c_bld    = iss.cls == fmitd_pkg::CLS_BLD;
  wire c_bst    = iss.cls == fmitd_pkg::CLS_BST;
  wire c_ldd    = iss.cls == fmitd_pkg::CLS_LDD;
  wire c_std    = iss.cls == fmitd_pkg::CLS_STD;
  wire c_ldtw   = iss.cls == fmitd_pkg::CLS_LDTW;
  wire c_pref   = iss.cls == fmitd_pkg::CLS_PREF;
  wire c_flush  = iss.cls == fmitd_pkg::CLS_FLUSH;
  wire c_rdpr   = iss.cls == fmitd_pkg::CLS_RDPR;
  wire c_ld     = iss.cls == fmitd_pkg::CLS_LD;
  wire c_st     = iss.cls == fmitd_pkg::CLS_ST;
  wire c_quad   = iss.cls == fmitd_pkg::CLS_LDQF
               || iss.cls == fmitd_pkg::CLS_STQF
               || iss.cls == fmitd_pkg::CLS_FPQUAD;
  wire c_impl   = iss.cls == fmitd_pkg::CLS_IMPL1
               || iss.cls == fmitd_pkg::CLS_IMPL2;

  wire c_store  = c_fst | c_bst | c_std | c_st;
  wire c_access = c_ld | c_st | c_fld | c_fst | c_ldd | c_std | c_ldtw
               | c_bld | c_bst;

  // access size by class; fp and integer plain forms carry their own
  wire [2:0] eff_size = (c_bld | c_bst) ? fmitd_pkg::SZ_BLOCK :
                        c_ldtw ? fmitd_pkg::SZ_TWIN :
                        (c_ldd | c_std) ? fmitd_pkg::SZ_DW :
                        iss.size;
  wire [6:0] low_mask  = 7'((7'h01 << eff_size) - 7'h01);
  wire       misal     = |(iss.addr[6:0] & low_mask);
  wire       fp_dbl    = (c_fld | c_fst) && iss.size == fmitd_pkg::SZ_DW;
  wire       ddf_mis   = fp_dbl && iss.addr[1:0] == 2'h0
                         && iss.addr[2];
  wire       gen_mis   = c_access & misal & ~ddf_mis;

  // prefetch function code groups
  wire pf_ill  = c_pref && iss.fcn >= fmitd_pkg::PF_ILL_LO
                 && iss.fcn <= fmitd_pkg::PF_ILL_HI;
  wire pf_inv  = c_pref && iss.fcn == fmitd_pkg::PF_INVAL
                 && hyperpriv && !iss.alt;
  wire pf_nop  = c_pref && (iss.fcn == fmitd_pkg::PF_PAGE
                 || iss.fcn >= fmitd_pkg::PF_NOP_LO
                 || (iss.fcn == fmitd_pkg::PF_INVAL && !pf_inv));
  wire pf_weak = c_pref & ~pf_ill & ~pf_nop;

  // only ieee exceptions enabled in tem trap; the other fp trap
  // types are never raised here
  wire [EW-1:0] fp_exc = c_fpop ? iss.fp_exc : '0;
  wire fp_trap = |(fp_exc & tem_r);
  wire illegal = pf_ill | (c_rdpr & iss.pr_que)
               | c_quad
               | c_impl;

  assign trap_nxt = illegal ? fmitd_pkg::TRAP_ILLEGAL :
                    ddf_mis ? (c_fst ? fmitd_pkg::TRAP_STDF_ALIGN
                                     : fmitd_pkg::TRAP_LDDF_ALIGN) :
                    gen_mis ? fmitd_pkg::TRAP_ALIGN :
                    fp_trap ? fmitd_pkg::TRAP_FP_IEEE :
                    fmitd_pkg::TRAP_NONE;
  wire trapped = trap_nxt != fmitd_pkg::TRAP_NONE;

  // dirty marks wait for successful completion, never on a trap
  wire wr_fp  = c_fpop | (c_fmov & iss.cond_ok) | c_gfx | c_fld
              | c_bld;
  wire set_hi = wr_fp & ~trapped & iss.dst_upper;
  wire set_lo = wr_fp & ~trapped & ~iss.dst_upper;

  // flush needs no translation so its address is dropped entirely
  wire mem_go = ~trapped & (c_access | pf_weak | pf_inv
              | c_flush);

  wire [7:0] data_asi = iss.alt ? iss.asi :
                        trap_level == 3'h0 ? asi_prim_r :
                        current_little_endian ? asi_kle_r
                                              : asi_kern_r;

  // a prefetch request other than the invalidate is the weak kind: the far side drops it on a miss
  assign mreq_nxt.kind   = c_flush ? fmitd_pkg::MK_FLUSH :
                           pf_inv  ? fmitd_pkg::MK_INVAL :
                           pf_weak ? fmitd_pkg::MK_PREF :
                           c_store ? fmitd_pkg::MK_STORE :
                           fmitd_pkg::MK_LOAD;
  assign mreq_nxt.addr   = c_flush ? 48'h0 : iss.addr;
  assign mreq_nxt.size   = eff_size;
  assign mreq_nxt.asi    = data_asi;
  assign mreq_nxt.rmo    = c_bld | c_bst;
  assign mreq_nxt.atomic = c_ldtw;
  assign done_nxt.trap   = accept ? trap_nxt : done_r.trap;
  assign done_nxt.asi    = accept ? data_asi : done_r.asi;

  // ---------------- sequencing ----------------
  // one request in flight at a time keeps every access in issue order,
  // which is what tso needs; the cost is no overlap of misses
  wire req_taken = mreq_valid_r & mreq_ready;
  wire flush_req = mreq_r.kind == fmitd_pkg::MK_FLUSH;
  logic finish;

  always_comb begin
    state_nxt = state_r;
    finish    = 1'b0;
    case (state_r)
      fmitd_pkg::ST_IDLE: begin
        if (accept && mem_go) begin
          state_nxt = fmitd_pkg::ST_REQ;
        end else if (accept) begin
          finish = 1'b1;
        end
      end
      fmitd_pkg::ST_REQ: begin
        if (req_taken && flush_req) begin
          state_nxt = fmitd_pkg::ST_FLW;
        end else if (req_taken) begin
          state_nxt = fmitd_pkg::ST_IDLE;
          finish    = 1'b1;
        end
      end
      fmitd_pkg::ST_FLW: begin
        if (flush_ack) begin
          state_nxt = fmitd_pkg::ST_IDLE;
          finish    = 1'b1;
        end
      end
      default: state_nxt = fmitd_pkg::ST_IDLE;
    endcase
  end

  wire app_hi = finish & (state_r == fmitd_pkg::ST_IDLE ? set_hi : pend_hi_r);
  wire app_lo = finish & (state_r == fmitd_pkg::ST_IDLE ? set_lo : pend_lo_r);

  // ---------------- register writes ----------------
  wire do_wr = ~awready_r & ~wready_r & ~bvalid_r;
  wire wr_frs  = do_wr && awaddr_r == fmitd_pkg::OFF_FRS;
  wire wr_fst  = do_wr && awaddr_r == fmitd_pkg::OFF_FST;
  wire wr_asi  = do_wr && awaddr_r == fmitd_pkg::OFF_ASI;
  wire wr_hit  = awaddr_r == fmitd_pkg::OFF_FRS
              || awaddr_r == fmitd_pkg::OFF_FST
              || awaddr_r == fmitd_pkg::OFF_ASI
              || awaddr_r == fmitd_pkg::OFF_STAT;
  wire [31:0] bmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                       {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0] fst_rd = {4'h0, tem_r, 9'h0, 1'b0, 3'h0, aexc_r,
                        cexc_r};
  wire [31:0] asi_rd = {8'h0, asi_kle_r, asi_kern_r, asi_prim_r};
  wire [31:0] fst_w  = (fst_rd & ~bmask) | (wdata_r & bmask);
  wire [31:0] asi_w  = (asi_rd & ~bmask) | (wdata_r & bmask);
  wire [31:0] frs_w  = ({30'h0, hi_r, lo_r} & ~bmask)
                     | (wdata_r & bmask);

  // hardware sets win over a software write in the same cycle
  wire hi_nxt = (wr_frs ? frs_w[fmitd_pkg::FRS_HI] : hi_r) | app_hi;
  wire lo_nxt = (wr_frs ? frs_w[fmitd_pkg::FRS_LO] : lo_r) | app_lo;
  wire fp_upd = accept & c_fpop & (trap_nxt == fmitd_pkg::TRAP_NONE
              || trap_nxt == fmitd_pkg::TRAP_FP_IEEE);
  wire [EW-1:0] aexc_sw = wr_fst ? fst_w[fmitd_pkg::FST_AEXC_LSB +: EW]
                                 : aexc_r;
  wire [EW-1:0] aexc_nxt = aexc_sw | ((fp_upd & ~fp_trap) ? fp_exc
                                                          : '0);
  wire [EW-1:0] cexc_nxt = fp_upd ? fp_exc :
                           wr_fst ? fst_w[fmitd_pkg::FST_CEXC_LSB +: EW]
                                  : cexc_r;

  // ---------------- register reads ----------------
  wire [31:0] rd_mux =
    s_axi_araddr == fmitd_pkg::OFF_FRS  ? {30'h0, hi_r, lo_r} :
    s_axi_araddr == fmitd_pkg::OFF_FST  ? fst_rd :
    s_axi_araddr == fmitd_pkg::OFF_ASI  ? asi_rd :
    s_axi_araddr == fmitd_pkg::OFF_STAT ?
      {25'h0, state_r, 1'b0, last_trap_r} : 32'h0;
  wire rd_hit = s_axi_araddr == fmitd_pkg::OFF_FRS
             || s_axi_araddr == fmitd_pkg::OFF_FST
             || s_axi_araddr == fmitd_pkg::OFF_ASI
             || s_axi_araddr == fmitd_pkg::OFF_STAT;
  wire rd_go = s_axi_arvalid & arready_r;

  // ---------------- flops ----------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r       <= fmitd_pkg::ST_IDLE;
      issue_ready_r <= 1'b0;
      done_valid_r  <= 1'b0;
      done_r        <= '0;
      mreq_valid_r  <= 1'b0;
      mreq_r        <= '0;
      last_trap_r   <= fmitd_pkg::TRAP_NONE;
      pend_hi_r     <= 1'b0;
      pend_lo_r     <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      issue_ready_r <= state_nxt == fmitd_pkg::ST_IDLE;
      done_valid_r  <= finish;
      done_r        <= done_nxt;
      mreq_valid_r  <= (accept & mem_go) | (mreq_valid_r & ~mreq_ready);
      mreq_r        <= (accept & mem_go) ? mreq_nxt : mreq_r;
      last_trap_r   <= accept ? trap_nxt : last_trap_r;
      pend_hi_r     <= accept ? set_hi : pend_hi_r;
      pend_lo_r     <= accept ? set_lo : pend_lo_r;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hi_r        <= 1'b0;
      lo_r        <= 1'b0;
      tem_r       <= '0;
      aexc_r      <= '0;
      cexc_r      <= '0;
      asi_prim_r  <= fmitd_pkg::ASI_PRIM_RST;
      asi_kern_r  <= fmitd_pkg::ASI_KERN_RST;
      asi_kle_r   <= fmitd_pkg::ASI_KLE_RST;
      fetch_asi_r <= fmitd_pkg::ASI_PRIM_RST;
    end else begin
      hi_r        <= hi_nxt;
      lo_r        <= lo_nxt;
      tem_r       <= wr_fst ? fst_w[fmitd_pkg::FST_TEM_LSB +: EW] : tem_r;
      aexc_r      <= aexc_nxt;
      cexc_r      <= cexc_nxt;
      asi_prim_r  <= wr_asi ? asi_w[fmitd_pkg::ASI_PRIM_LSB +: 8]
                            : asi_prim_r;
      asi_kern_r  <= wr_asi ? asi_w[fmitd_pkg::ASI_KERN_LSB +: 8]
                            : asi_kern_r;
      asi_kle_r   <= wr_asi ? asi_w[fmitd_pkg::ASI_KLE_LSB +: 8]
                            : asi_kle_r;
      fetch_asi_r <= trap_level != 3'h0 ? asi_kern_r
                                        : asi_prim_r;
    end
  end

  // axi write: address and data latched in either order
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= fmitd_pkg::RESP_OKAY;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
    end else begin
      awready_r <= do_wr | (awready_r & ~s_axi_awvalid);
      wready_r  <= do_wr | (wready_r & ~s_axi_wvalid);
      awaddr_r  <= (awready_r & s_axi_awvalid) ? s_axi_awaddr : awaddr_r;
      wdata_r   <= (wready_r & s_axi_wvalid) ? s_axi_wdata : wdata_r;
      wstrb_r   <= (wready_r & s_axi_wvalid) ? s_axi_wstrb : wstrb_r;
      bvalid_r  <= do_wr | (bvalid_r & ~s_axi_bready);
      bresp_r   <= do_wr ? (wr_hit ? fmitd_pkg::RESP_OKAY
                                   : fmitd_pkg::RESP_SLVERR) : bresp_r;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= fmitd_pkg::RESP_OKAY;
      rdata_r   <= 32'h0;
    end else begin
      arready_r <= (arready_r & ~s_axi_arvalid) | (rvalid_r & s_axi_rready);
      rvalid_r  <= rd_go | (rvalid_r & ~s_axi_rready);
      rdata_r   <= rd_go ? rd_mux : rdata_r;
      rresp_r   <= rd_go ? (rd_hit ? fmitd_pkg::RESP_OKAY
                                   : fmitd_pkg::RESP_SLVERR) : rresp_r;
    end
  end

  assign issue_ready    = issue_ready_r;
  assign done_valid     = done_valid_r;
  assign done_info      = done_r;
  assign fetch_asi      = fetch_asi_r;
  assign fp_dirty_upper = hi_r;
  assign fp_dirty_lower = lo_r;
  assign mreq_valid     = mreq_valid_r;
  assign mreq           = mreq_r;
  assign s_axi_awready  = awready_r;
  assign s_axi_wready   = wready_r;
  assign s_axi_bvalid   = bvalid_r;
  assign s_axi_bresp    = bresp_r;
  assign s_axi_arready  = arready_r;
  assign s_axi_rvalid   = rvalid_r;
  assign s_axi_rresp    = rresp_r;
  assign s_axi_rdata    = rdata_r;

endmodule

/* fmitd_chk.sv */
// fmitd_chk: port-level checks of fmitd_top.
// assumes a single clock domain; bound into fmitd_top below.
`timescale 1ns/10ps
module fmitd_chk (
  input wire logic                   clock,
  input wire logic                   sys_rst,
  input wire logic                   done_valid,
  input wire fmitd_pkg::fmitd_done_s done_info,
  input wire logic                   fp_dirty_upper,
  input wire logic                   fp_dirty_lower,
  input wire logic                   mreq_valid,
  input wire fmitd_pkg::fmitd_mreq_s mreq,
  input wire logic                   mreq_ready,
  input wire logic                   flush_ack,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic [7:0]             s_axi_araddr,
  input wire logic                   s_axi_rvalid,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic                   s_axi_bvalid
);
  logic [7:0] ra_r;
  logic       fw_r;
  // fw_r marks a flush that is out but not yet acknowledged
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ra_r <= 8'h00;
      fw_r <= 1'b0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
      fw_r <= (fw_r && !flush_ack) || (mreq_valid && mreq_ready &&
              mreq.kind == fmitd_pkg::MK_FLUSH);
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_qne_zero: assert property (s_axi_rvalid && ra_r == 8'h04 |->
    !s_axi_rdata[13]) else $error("queue flag set");
  a_trap_no_mreq: assert property (done_valid &&
    done_info.trap != fmitd_pkg::TRAP_NONE |-> !mreq_valid)
    else $error("trap made a request");
  a_dirty_cause: assert property (($rose(fp_dirty_upper) ||
    $rose(fp_dirty_lower)) && !s_axi_bvalid |-> done_valid &&
    done_info.trap == fmitd_pkg::TRAP_NONE) else $error("dirty set");
  a_mreq_hold: assert property (mreq_valid && !mreq_ready |=>
    mreq_valid && $stable(mreq)) else $error("request dropped");
  a_flush_wait: assert property (fw_r && !flush_ack |=>
    !done_valid) else $error("flush done early");
  a_flush_done: assert property (fw_r && flush_ack |=>
    done_valid) else $error("flush not done");
  a_block_rmo: assert property (mreq_valid |-> mreq.rmo ==
    (mreq.size == 3'h6)) else $error("rmo wrong");
  a_twin_atomic: assert property (mreq_valid && mreq.atomic |->
    mreq.size == 3'h4 && mreq.kind == fmitd_pkg::MK_LOAD)
    else $error("twin wrong");
endmodule

bind fmitd_top fmitd_chk u_chk (.clock, .sys_rst, .done_valid,
  .done_info, .fp_dirty_upper, .fp_dirty_lower, .mreq_valid, .mreq,
  .mreq_ready, .flush_ack, .s_axi_arvalid, .s_axi_arready,
  .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .s_axi_bvalid);

/* fmitd_l2_model.sv */
// fmitd_l2_model: level-2 side taking requests, acknowledging flushes.
// assumes the core clock; slow makes each request wait three cycles.
`timescale 1ns/10ps
module fmitd_l2_model (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire logic                   slow,
  input  wire logic                   mreq_valid,
  input  wire fmitd_pkg::fmitd_mreq_s mreq,
  output logic                        mreq_ready,
  output logic                        flush_ack
);
  logic [1:0] wait_r;
  logic       pend_r;
  assign mreq_ready = mreq_valid && (!slow || wait_r == 2'h3);
  // ack two cycles after the flush is taken so the core must really wait for it
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wait_r <= 2'h0;
      pend_r <= 1'b0;
      flush_ack <= 1'b0;
    end else begin
      wait_r <= (mreq_valid && !mreq_ready) ? wait_r + 2'h1 : 2'h0;
      pend_r <= mreq_ready && mreq.kind == fmitd_pkg::MK_FLUSH;
      flush_ack <= pend_r;
    end
  end
endmodule

/* fmitd_top_tb.sv */
// fmitd_top_tb: issues instructions and bus accesses, checks results.
// assumes fmitd_top, fmitd_l2_model and the bound checker.
`timescale 1ns/10ps
module fmitd_top_tb;
  logic clock, sys_rst, issue_valid, issue_ready, hyperpriv, slow;
  logic current_little_endian, done_valid, mreq_valid, mreq_ready;
  logic fp_dirty_upper, fp_dirty_lower, flush_ack, s_axi_awvalid;
  logic s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready;
  logic [2:0]  trap_level;
  logic [3:0]  s_axi_wstrb, fl;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [7:0]  fetch_asi, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  fmitd_pkg::fmitd_issue_s issue_insn;
  fmitd_pkg::fmitd_done_s  done_info, dn;
  fmitd_pkg::fmitd_mreq_s  mreq, lq;
  int mismatches, n_tests, nreq, n0, i;
  fmitd_top DUT (.*);
  fmitd_l2_model L2 (.*);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) if (mreq_valid && mreq_ready) begin
    lq <= mreq;
    nreq <= nreq + 1;
  end
  task automatic cv(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ct(input fmitd_pkg::fmitd_trap_e e, g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value trap expected %s seen %s", e.name, g.name);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    for (int k = 0; k < 30; k++) begin
      @(negedge clock);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) break;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic ta, tv;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int k = 0; k < 30; k++) begin
      @(negedge clock);
      ta = s_axi_arvalid && s_axi_arready;
      tv = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tv) break;
    end
    cv("rdata", e, rv);
    cv("rresp", er, rr);
  endtask
  task automatic op(input fmitd_pkg::fmitd_cls_e c, input logic [4:0] x,
    input logic [47:0] a, input logic [2:0] s, fmitd_pkg::fmitd_trap_e t);
    fmitd_pkg::fmitd_issue_s v;
    logic tk, dv;
    v = '0;
    {v.cls, v.fp_exc, v.fcn, v.addr, v.size} = {c, x, x, a, s};
    {v.pr_que, v.alt, v.cond_ok, v.dst_upper} = fl;
    issue_insn <= v;
    issue_valid <= 1'b1;
    for (int k = 0; k < 30; k++) begin
      @(negedge clock);
      tk = issue_valid && issue_ready;
      dv = done_valid;
      dn = done_info;
      @(posedge clock);
      if (tk) issue_valid <= 1'b0;
      if (dv) break;
    end
    ct(t, dn.trap);
  endtask
  task automatic final_report;
    if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    final_report;
  end
  initial begin
    {sys_rst, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7f;
    {issue_valid, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {hyperpriv, slow, current_little_endian, trap_level, fl} = '0;
    {issue_insn, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {mismatches, n_tests, nreq} = '0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rd(8'h08, 32'h00282010, 2'h0);
    rd(8'h10, 32'h0, 2'h2);
    op(fmitd_pkg::CLS_FPOP, 5'h0, 0, 0, fmitd_pkg::TRAP_NONE);
    cv("dirty", 2'h1, {fp_dirty_upper, fp_dirty_lower});
    fl = 4'h1;
    op(fmitd_pkg::CLS_FMOVCC, 5'h0, 0, 0, fmitd_pkg::TRAP_NONE);
    cv("dirty", 2'h1, {fp_dirty_upper, fp_dirty_lower});
    op(fmitd_pkg::CLS_GFX, 5'h0, 0, 0, fmitd_pkg::TRAP_NONE);
    cv("dirty", 2'h3, {fp_dirty_upper, fp_dirty_lower});
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h00800000);
    op(fmitd_pkg::CLS_FPOP, 5'h1, 0, 0, fmitd_pkg::TRAP_FP_IEEE);
    cv("dirty", 2'h0, {fp_dirty_upper, fp_dirty_lower});
    rd(8'h04, 32'h00800001, 2'h0);
    wr(8'h04, 32'h0);
    op(fmitd_pkg::CLS_FPOP, 5'h2, 0, 0, fmitd_pkg::TRAP_NONE);
    rd(8'h04, 32'h00000042, 2'h0);
    fl = 4'h8;
    op(fmitd_pkg::CLS_RDPR, 0, 0, 0, fmitd_pkg::TRAP_ILLEGAL);
    fl = 4'h0;
    op(fmitd_pkg::CLS_LDQF, 0, 0, 0, fmitd_pkg::TRAP_ILLEGAL);
    op(fmitd_pkg::CLS_STQF, 0, 0, 0, fmitd_pkg::TRAP_ILLEGAL);
    op(fmitd_pkg::CLS_IMPL1, 0, 0, 0, fmitd_pkg::TRAP_ILLEGAL);
    op(fmitd_pkg::CLS_IMPL2, 0, 0, 0, fmitd_pkg::TRAP_ILLEGAL);
    hyperpriv <= 1'b1;
    for (i = 0; i < 32; i++) begin
      n0 = nreq;
      op(fmitd_pkg::CLS_PREF, i[4:0], 48'h40, 0, (i > 4 && i < 16) ?
         fmitd_pkg::TRAP_ILLEGAL : fmitd_pkg::TRAP_NONE);
      cv("pref_req", i < 4 || (i > 15 && i < 25), nreq - n0);
      if (nreq != n0) cv("pref_kind", (i == 24) ? fmitd_pkg::MK_INVAL :
                        fmitd_pkg::MK_PREF, lq.kind);
    end
    hyperpriv <= 1'b0;
    n0 = nreq;
    op(fmitd_pkg::CLS_PREF, 5'h18, 0, 0, fmitd_pkg::TRAP_NONE);
    cv("inval_user", 0, nreq - n0);
    op(fmitd_pkg::CLS_FLD, 0, 48'h4, 3'h3, fmitd_pkg::TRAP_LDDF_ALIGN);
    op(fmitd_pkg::CLS_FST, 0, 48'h4, 3'h3, fmitd_pkg::TRAP_STDF_ALIGN);
    op(fmitd_pkg::CLS_FLD, 0, 48'h8, 3'h3, fmitd_pkg::TRAP_NONE);
    slow <= 1'b1;
    n0 = nreq;
    op(fmitd_pkg::CLS_LDD, 0, 48'h10, 3'h3, fmitd_pkg::TRAP_NONE);
    cv("ldd_req", 1, nreq - n0);
    op(fmitd_pkg::CLS_LDTW, 0, 48'h20, 3'h4, fmitd_pkg::TRAP_NONE);
    cv("twin", 1, lq.atomic);
    op(fmitd_pkg::CLS_BLD, 0, 48'h40, 3'h6, fmitd_pkg::TRAP_NONE);
    cv("block", 4'he, {lq.rmo, lq.size});
    op(fmitd_pkg::CLS_FLUSH, 0, 48'h123, 0, fmitd_pkg::TRAP_NONE);
    cv("flush", fmitd_pkg::MK_FLUSH, lq.kind);
    cv("flush_addr", 0, lq.addr[31:0]);
    trap_level <= 3'h1;
    op(fmitd_pkg::CLS_LD, 0, 48'h8, 3'h3, fmitd_pkg::TRAP_NONE);
    cv("data_asi", 8'h20, dn.asi);
    cv("fetch_asi", 8'h20, fetch_asi);
    current_little_endian <= 1'b1;
    op(fmitd_pkg::CLS_LD, 0, 48'h8, 3'h3, fmitd_pkg::TRAP_NONE);
    cv("data_asi", 8'h28, dn.asi);
    final_report;
  end
endmodule
